// *** hw/sfr_pkg.sv ***
// Package for the serial flash read path: command codes, dummy counts,
// protocol and decode types shared by both ends of the link.
// Assumes both ends see the same protocol and address-mode settings.
package sfr_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_CMD_READ = 8'h03;
  localparam logic [7:0] SFR_CMD_FAST = 8'h0B;
  localparam logic [7:0] SFR_CMD_DOUT2 = 8'h3B;
  localparam logic [7:0] SFR_CMD_DIO2 = 8'hBB;
  localparam logic [7:0] SFR_CMD_DOUT4 = 8'h6B;
  localparam logic [7:0] SFR_CMD_DIO4 = 8'hEB;
  localparam logic [7:0] SFR_CMD_FAST_DE = 8'h0D;
  localparam logic [7:0] SFR_CMD_DOUT2_DE = 8'h3D;
  localparam logic [7:0] SFR_CMD_DIO2_DE = 8'hBD;
  localparam logic [7:0] SFR_CMD_DOUT4_DE = 8'h6D;
  localparam logic [7:0] SFR_CMD_DIO4_DE = 8'hED;
  localparam logic [7:0] SFR_CMD_WIDE_ENTER = 8'hB7;
  localparam logic [7:0] SFR_CMD_WIDE_LEAVE = 8'hE9;

  // ----------------------------------------------------------------
  // dummy clocks and geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] SFR_DUMMY_EXT_FAST = 5'h08;
  localparam logic [4:0] SFR_DUMMY_EXT_WIDE = 5'h07;
  localparam logic [4:0] SFR_DUMMY_EXT_DIO4 = 5'h09;
  localparam logic [4:0] SFR_DUMMY_DUAL = 5'h07;
  localparam logic [4:0] SFR_DUMMY_QUAD = 5'h09;
  localparam logic [2:0] SFR_EXEC_IN_PLACE_CONFIRM = 3'h1;
  localparam int SFR_DIE_BITS = 25;
  localparam int SFR_HALF_DIV_DEF = 4;

  typedef enum logic [1:0] {SFR_PROTO_EXT, SFR_PROTO_DUAL, SFR_PROTO_QUAD} sfr_proto_t;

  typedef struct packed {
    logic ok;
    logic dbl;
    logic [2:0] aw;
    logic [2:0] dw;
    logic [4:0] dummy;
  } sfr_dec_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] sfr_proto_lanes(input sfr_proto_t p);
    unique case (p)
      SFR_PROTO_DUAL: return 3'h2;
      SFR_PROTO_QUAD: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction

  function automatic logic [3:0] sfr_lane_mask(input logic [2:0] w);
    return (w == 3'h4) ? 4'hF : ((w == 3'h2) ? 4'h3 : 4'h1);
  endfunction

  function automatic logic [31:0] sfr_shin(input logic [31:0] v, input logic [3:0] l,
                                           input logic [2:0] w);
    unique case (w)
      3'h2: return {v[29:0], l[1:0]};
      3'h4: return {v[27:0], l};
      default: return {v[30:0], l[0]};
    endcase
  endfunction

  function automatic sfr_dec_t sfr_decode(input logic [7:0] code, input sfr_proto_t p);
    sfr_dec_t d;
    logic [2:0] k;
    d = '0;
    unique case (code)
      SFR_CMD_READ: k = 3'h1;
      SFR_CMD_FAST, SFR_CMD_FAST_DE: k = 3'h2;
      SFR_CMD_DOUT2, SFR_CMD_DOUT2_DE: k = 3'h3;
      SFR_CMD_DIO2, SFR_CMD_DIO2_DE: k = 3'h4;
      SFR_CMD_DOUT4, SFR_CMD_DOUT4_DE: k = 3'h5;
      SFR_CMD_DIO4, SFR_CMD_DIO4_DE: k = 3'h6;
      default: k = 3'h0;
    endcase
    d.dbl = (code[3:0] == 4'hD);
    unique case (p)
      SFR_PROTO_DUAL: begin
        d.ok = (k == 3'h2) || (k == 3'h3) || (k == 3'h4);
        d.aw = 3'h2;
        d.dw = 3'h2;
        d.dummy = SFR_DUMMY_DUAL;
      end
      SFR_PROTO_QUAD: begin
        d.ok = (k == 3'h2) || (k == 3'h5) || (k == 3'h6);
        d.aw = 3'h4;
        d.dw = 3'h4;
        d.dummy = SFR_DUMMY_QUAD;
      end
      default: begin
        d.ok = (k != 3'h0);
        d.aw = (k == 3'h4) ? 3'h2 : ((k == 3'h6) ? 3'h4 : 3'h1);
        d.dw = (k <= 3'h2) ? 3'h1 : ((k <= 3'h4) ? 3'h2 : 3'h4);
        d.dummy = (k == 3'h1) ? 5'h00 : ((k == 3'h2) ? SFR_DUMMY_EXT_FAST :
                  ((k == 3'h6) ? SFR_DUMMY_EXT_DIO4 : SFR_DUMMY_EXT_WIDE));
      end
    endcase
    return d;
  endfunction

endpackage

// *** hw/sfr_link_if.sv ***
// Link between host controller and flash read path: select, clock, 4 lanes.
// Lanes are resolved here from both enables; an undriven lane reads as 1.
interface sfr_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] host_out;
  logic [3:0] host_oe;
  logic [3:0] dev_out;
  logic [3:0] dev_oe;
  logic [3:0] lane;

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane[i] = host_oe[i] ? host_out[i] : (dev_oe[i] ? dev_out[i] : 1'b1);
  end

  modport host(output cs_n, output sck, output host_out, output host_oe, input lane);
  modport dev(input cs_n, input sck, input lane, output dev_out, output dev_oe);
endinterface

// *** hw/sfr_flash_dev.sv ***
// Flash end of the read path: decodes read commands, takes the address,
// counts dummy clocks and streams bytes from an incrementing address.
// Assumes a combinational byte store behind mem_addr and a mode-0 link clock.
//
// Contract
// - default address is three bytes, 24 bits
// - wide mode takes four address bytes
// - wide mode set by strap or commands
// - address wraps inside the same die
// - host reads each die with separate command
// - host lowers select, sends command, address
// - address bits sampled on rising link clock
// - address advances by one per byte
// - select high stops output, abandons read
// - single and double edge codes decoded
// - extended protocol lane use per command
// - dual and quad protocols restrict commands
// - dummy-cycle reads wait before data
// - dual protocol needs seven dummy clocks
// - quad protocol needs nine dummy clocks
module sfr_flash_dev
  import sfr_pkg::*;
(
  sfr_link_if.dev link,
  input wire logic nrst,
  input wire logic nv_wide_addr,
  input wire sfr_proto_t proto,
  input wire logic [7:0] mem_rdata,
  output logic [31:0] mem_addr,
  output logic wide_addr_active,
  output logic read_active
);

  // ----------------------------------------------------------------
  // state and declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_CMD,
    DS_ADDR,
    DS_DUMMY,
    DS_DATA,
    DS_IGNORE
  } sfr_dstate_t;

  sfr_dstate_t st_q;
  sfr_dstate_t st_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  sfr_dec_t dec_q;
  sfr_dec_t dec_d;
  logic wide_set_q;
  logic wide_val_q;
  logic [7:0] byte_q;
  logic oe_q;

  logic frame_rst_n;
  logic [2:0] cmd_w;
  logic [31:0] cmd_shift;
  logic [7:0] cmd_code;
  sfr_dec_t dec_now;
  logic [31:0] addr_shift;
  logic [5:0] addr_clks;
  logic cmd_last;
  logic addr_last;
  logic dummy_last;
  logic byte_last;
  logic wide_hit;
  logic [SFR_DIE_BITS-1:0] die_next;
  logic [3:0] data_out;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // select high clears the whole frame at once, even with the clock stopped
  assign frame_rst_n = nrst & ~link.cs_n;

  assign wide_addr_active = wide_set_q ? wide_val_q : nv_wide_addr;

  assign cmd_w = sfr_proto_lanes(proto);
  assign cmd_shift = sfr_shin({24'h000000, cmd_q}, link.lane, cmd_w);
  assign cmd_code = cmd_shift[7:0];
  assign dec_now = sfr_decode(cmd_code, proto);
  assign addr_shift = sfr_shin(addr_q, link.lane, dec_q.aw);

  assign addr_clks = wide_addr_active ? 6'h20 : 6'h18;
  assign cmd_last = (cnt_q == (6'h08 >> cmd_w[2:1]) - 6'h01);
  assign addr_last = (cnt_q == (addr_clks >> dec_q.aw[2:1]) - 6'h01);
  assign dummy_last = (cnt_q == {1'b0, dec_q.dummy} - 6'h01);
  assign byte_last = (cnt_q == (6'h08 >> dec_q.dw[2:1]) - 6'h01);

  assign wide_hit = (st_q == DS_CMD) && cmd_last &&
                    ((cmd_code == SFR_CMD_WIDE_ENTER) || (cmd_code == SFR_CMD_WIDE_LEAVE));

  // low die bits roll over, die select bits stay put
  assign die_next = addr_q[SFR_DIE_BITS-1:0] + 1'b1;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 6'h01;
    cmd_d = cmd_q;
    addr_d = addr_q;
    dec_d = dec_q;
    unique case (st_q)
      DS_CMD: begin
        cmd_d = cmd_code;
        if (cmd_last) begin
          cnt_d = 6'h00;
          addr_d = 32'h00000000;
          dec_d = dec_now;
          // bad codes and mode commands leave the lanes alone
          st_d = dec_now.ok ? DS_ADDR : DS_IGNORE;
        end
      end
      DS_ADDR: begin
        addr_d = addr_shift;
        if (addr_last) begin
          cnt_d = 6'h00;
          st_d = (dec_q.dummy == 5'h00) ? DS_DATA : DS_DUMMY;
        end
      end
      DS_DUMMY: begin
        if (dummy_last) begin
          cnt_d = 6'h00;
          st_d = DS_DATA;
        end
      end
      DS_DATA: begin
        if (byte_last) begin
          cnt_d = 6'h00;
          addr_d = {addr_q[31:SFR_DIE_BITS], die_next};
        end
      end
      DS_IGNORE: begin
        cnt_d = cnt_q;
      end
      default: begin
        st_d = DS_IGNORE;
      end
    endcase
  end

  always_ff @(posedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      st_q <= DS_CMD;
      cnt_q <= 6'h00;
      cmd_q <= 8'h00;
      addr_q <= 32'h00000000;
      dec_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      dec_q <= dec_d;
    end
  end

  // ----------------------------------------------------------------
  // address mode
  // ----------------------------------------------------------------
  // survives select high; only a full reset returns to the strap
  always_ff @(posedge link.sck or negedge nrst) begin
    if (!nrst) begin
      wide_set_q <= 1'b0;
      wide_val_q <= 1'b0;
    end else if (wide_hit) begin
      wide_set_q <= 1'b1;
      wide_val_q <= (cmd_code == SFR_CMD_WIDE_ENTER);
    end
  end

  // ----------------------------------------------------------------
  // data output
  // ----------------------------------------------------------------
  // launch on the falling edge so the host sees a full half period of setup
  always_ff @(negedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      byte_q <= 8'h00;
      oe_q <= 1'b0;
    end else if (st_q == DS_DATA) begin
      oe_q <= 1'b1;
      if (cnt_q == 6'h00) begin
        byte_q <= mem_rdata;
      end else begin
        byte_q <= byte_q << dec_q.dw;
      end
    end else begin
      oe_q <= 1'b0;
    end
  end

  assign data_out = (dec_q.dw == 3'h4) ? byte_q[7:4] :
                    ((dec_q.dw == 3'h2) ? {2'b00, byte_q[7:6]} : {2'b00, byte_q[7], 1'b0});

  // single-lane data leaves on lane one, never on the command lane
  assign link.dev_out = data_out;
  assign link.dev_oe = oe_q ? ((dec_q.dw == 3'h1) ? 4'h2 : sfr_lane_mask(dec_q.dw)) : 4'h0;

  assign mem_addr = addr_q;
  assign read_active = (st_q == DS_DATA);

endmodule // sfr_flash_dev

// *** hw/sfr_flash_host.sv ***
// Host end of the read path: makes the link clock by dividing sys_clk,
// sends command and address, and returns bytes through a two-entry buffer.
// Assumes the flash end launches data on the falling link clock.
module sfr_flash_host
  import sfr_pkg::*;
#(
  parameter int HALF_DIV = SFR_HALF_DIV_DEF
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  sfr_link_if.host link,
  input wire sfr_proto_t proto,
  input wire logic wide_addr,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_code,
  input wire logic [31:0] req_addr,
  input wire logic [15:0] req_len,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic done
);

  // the lane synchroniser eats two cycles of each half period
  if (HALF_DIV < 3 || HALF_DIV > 256) begin : g_bad_div
    $error("HALF_DIV must be 3 to 256");
  end

  localparam logic [7:0] HC_LAST = 8'(HALF_DIV - 1);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {HS_IDLE, HS_CMD, HS_ADDR, HS_DUMMY, HS_DATA, HS_END} sfr_hstate_t;

  sfr_hstate_t st_q;
  logic [7:0] hc_q;
  logic sck_q;
  logic cs_n_q;
  logic [5:0] cnt_q;
  logic [39:0] sh_q;
  sfr_dec_t dec_q;
  logic wide_q;
  logic [15:0] left_q;
  logic [7:0] rx_q;
  logic done_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [7:0] buf_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] fill_q;

  logic [2:0] cmd_w;
  logic [2:0] cur_w;
  logic full;
  logic stall;
  logic run;
  logic tick;
  logic rise;
  logic fall;
  logic accept;
  logic push;
  logic pop;
  logic last;
  logic [3:0] rx_pick;
  logic [31:0] rx_shift;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign cmd_w = sfr_proto_lanes(proto);
  assign cur_w = (st_q == HS_CMD) ? cmd_w : dec_q.aw;
  assign full = (fill_q == 2'h2);
  // hold the clock low before a byte the buffer could not take
  assign stall = (st_q == HS_DATA) && (cnt_q == 6'h00) && !sck_q && full;
  assign run = (st_q != HS_IDLE) && (st_q != HS_END) && !stall;
  assign tick = (hc_q == HC_LAST);
  assign rise = run && tick && !sck_q;
  assign fall = run && tick && sck_q;
  assign accept = req_valid && (st_q == HS_IDLE);
  assign req_ready = (st_q == HS_IDLE);

  always_comb begin
    unique case (st_q)
      HS_CMD: last = (cnt_q == (6'h08 >> cmd_w[2:1]) - 6'h01);
      HS_ADDR: last = (cnt_q == ((wide_q ? 6'h20 : 6'h18) >> dec_q.aw[2:1]) - 6'h01);
      HS_DUMMY: last = (cnt_q == {1'b0, dec_q.dummy} - 6'h01);
      HS_DATA: last = (cnt_q == (6'h08 >> dec_q.dw[2:1]) - 6'h01);
      default: last = 1'b0;
    endcase
  end

  assign push = fall && (st_q == HS_DATA) && last;
  assign pop = rd_valid && rd_ready;
  assign rx_pick = (dec_q.dw == 3'h1) ? {3'b000, sync2_q[1]} : sync2_q;
  assign rx_shift = sfr_shin({24'h000000, rx_q}, rx_pick, dec_q.dw);

  // ----------------------------------------------------------------
  // lane synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= link.lane;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= HS_IDLE;
      hc_q <= 8'h00;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      cnt_q <= 6'h00;
      sh_q <= 40'h0000000000;
      dec_q <= '0;
      wide_q <= 1'b0;
      left_q <= 16'h0000;
      rx_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      hc_q <= (tick || !(run || st_q == HS_END)) ? 8'h00 : hc_q + 8'h01;
      if (rise || fall) begin
        sck_q <= !sck_q;
      end
      if (rise && st_q == HS_DATA) begin
        rx_q <= rx_shift[7:0];
      end
      if (accept) begin
        st_q <= HS_CMD;
        cs_n_q <= 1'b0;
        cnt_q <= 6'h00;
        wide_q <= wide_addr;
        dec_q <= sfr_decode(req_code, proto);
        left_q <= req_len;
        sh_q <= wide_addr ? {req_code, req_addr} : {req_code, req_addr[23:0], 8'h00};
      end else if (st_q == HS_END) begin
        if (tick) begin
          st_q <= HS_IDLE;
          done_q <= 1'b1;
        end
      end else if (fall) begin
        cnt_q <= last ? 6'h00 : cnt_q + 6'h01;
        if (st_q == HS_CMD || st_q == HS_ADDR) begin
          sh_q <= sh_q << cur_w;
        end
        if (last) begin
          unique case (st_q)
            HS_CMD: st_q <= dec_q.ok ? HS_ADDR : HS_END;
            HS_ADDR: st_q <= (dec_q.dummy == 5'h00) ? HS_DATA : HS_DUMMY;
            HS_DUMMY: st_q <= HS_DATA;
            default: begin
              left_q <= left_q - 16'h0001;
              if (left_q == 16'h0000) begin
                st_q <= HS_END;
              end
            end
          endcase
          if ((st_q == HS_DATA && left_q == 16'h0000) || (st_q == HS_CMD && !dec_q.ok)) begin
            cs_n_q <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // two-entry receive buffer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= !wp_q;
      end
      if (pop) begin
        rp_q <= !rp_q;
      end
      fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_q[wp_q] <= rx_q;
    end
  end

  assign rd_valid = (fill_q != 2'h0);
  assign rd_data = buf_q[rp_q];
  assign done = done_q;

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.host_out = (cur_w == 3'h4) ? sh_q[39:36] :
                         ((cur_w == 3'h2) ? {2'b00, sh_q[39:38]} : {3'b000, sh_q[39]});
  assign link.host_oe = (st_q == HS_CMD || st_q == HS_ADDR) ? sfr_lane_mask(cur_w) : 4'h0;

endmodule // sfr_flash_host

// *** test/sfr_link_checker.sv ***
// Checker for the flash read link: clock shape, lane ownership, frame edges.
// Assumes sck is made from sys_clk by the host divider; sees link wires and proto only.
module sfr_link_checker
  import sfr_pkg::*;
#(
  parameter int HALF_DIV = 4
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire sfr_proto_t proto,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] host_out,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [7:0] hi_cnt_q;
  logic [7:0] hi_cnt_d;
  logic [3:0] cmd_mask;
  logic is_ext;
  assign hi_cnt_d = sck ? hi_cnt_q + 8'h01 : 8'h00;
  assign cmd_mask = (proto == SFR_PROTO_QUAD) ? 4'hF : ((proto == SFR_PROTO_DUAL) ? 4'h3 : 4'h1);
  assign is_ext = (proto == SFR_PROTO_EXT);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_q <= 8'h00;
    end else begin
      hi_cnt_q <= hi_cnt_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_sck_first;
    !sck ##1 !sck ##[1:4] $rose(sck);
  endsequence
  property p_first_rise; $fell(cs_n) |-> s_sck_first; endproperty
  property p_cmd_lanes; $fell(cs_n) |-> host_oe == cmd_mask; endproperty
  property p_sck_high; $fell(sck) |-> hi_cnt_q == HALF_DIV; endproperty
  property p_sck_idle; cs_n && $past(cs_n) |-> !sck; endproperty
  property p_host_hold; sck && $past(sck) |-> $stable(host_out & host_oe); endproperty
  property p_dev_hold; sck && $past(sck) |-> $stable(dev_out & dev_oe); endproperty
  property p_no_clash; (host_oe & dev_oe) == 4'h0; endproperty
  property p_dev_quiet_cmd; $fell(cs_n) |-> (dev_oe == 4'h0) [*8]; endproperty
  property p_dev_off_idle; cs_n && $past(cs_n) |-> dev_oe == 4'h0; endproperty
  property p_host_release; cs_n && $past(cs_n) |-> host_oe == 4'h0; endproperty
  property p_ext_lane1; is_ext && dev_oe != 4'h0 |-> dev_oe[1]; endproperty

  a_first_rise: assert property (p_first_rise) else $error("sck late after select");
  a_cmd_lanes: assert property (p_cmd_lanes) else $error("command lanes wrong");
  a_sck_high: assert property (p_sck_high) else $error("sck high phase wrong");
  a_sck_idle: assert property (p_sck_idle) else $error("sck moves while idle");
  a_host_hold: assert property (p_host_hold) else $error("host lanes move on high");
  a_dev_hold: assert property (p_dev_hold) else $error("device lanes move on high");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive a lane");
  a_dev_quiet_cmd: assert property (p_dev_quiet_cmd) else $error("device drives in command");
  a_dev_off_idle: assert property (p_dev_off_idle) else $error("device drives while idle");
  a_host_release: assert property (p_host_release) else $error("host drives while idle");
  a_ext_lane1: assert property (p_ext_lane1) else $error("single data not on lane one");
endmodule // sfr_link_checker

// *** test/serial_flash_read_path_test.sv ***
// Bench joining host and flash ends; reads through the host request port.
// Assumes a combinational byte store model behind the flash end.
module serial_flash_read_path_test
  import sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_DIV = 4;
  logic sys_clk, nrst, nv_wide, wide, req_valid, rd_ready;
  sfr_proto_t proto;
  logic [7:0] req_code, cmd_sh;
  logic [31:0] req_addr;
  logic [15:0] req_len;
  logic [3:0] lmask;
  logic req_ready, rd_valid, done, wide_act, rd_act;
  logic [7:0] rd_data, mem_rdata;
  logic [31:0] mem_addr;
  int n_mismatch, tests_run, cyc, n_rise, cw;
  logic [7:0] codes [11] = '{8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB,
                             8'h0D, 8'h3D, 8'hBD, 8'h6D, 8'hED};

  // ----------------------------------------------------------------
  // ends and store
  // ----------------------------------------------------------------
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[22:15] ^ {a[31:30], 5'h00, a[24]};
  endfunction
  assign mem_rdata = mem_byte(mem_addr);
  sfr_link_if link();
  sfr_flash_host #(.HALF_DIV(HALF_DIV)) u_sfr_flash_host (.sys_clk(sys_clk), .nrst(nrst),
    .link(link), .proto(proto), .wide_addr(wide), .req_valid(req_valid), .req_ready(req_ready),
    .req_code(req_code), .req_addr(req_addr), .req_len(req_len), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .done(done));
  sfr_flash_dev u_sfr_flash_dev (.link(link), .nrst(nrst), .nv_wide_addr(nv_wide),
    .proto(proto), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .wide_addr_active(wide_act),
    .read_active(rd_act));
  sfr_link_checker #(.HALF_DIV(HALF_DIV)) u_sfr_link_checker (.sys_clk(sys_clk), .nrst(nrst),
    .proto(proto), .cs_n(link.cs_n), .sck(link.sck), .host_out(link.host_out),
    .host_oe(link.host_oe), .dev_out(link.dev_out), .dev_oe(link.dev_oe));

  // ----------------------------------------------------------------
  // clock, timeout, wire monitor
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  always @(negedge link.cs_n) begin
    n_rise = 0;
    cmd_sh = 8'h00;
  end
  // rises counted per frame; first 8/cw of them carry the command
  always @(posedge link.sck) begin
    if (!link.cs_n) begin
      if (n_rise * cw < 8) cmd_sh = (cmd_sh << cw) | 8'(link.lane & lmask);
      n_rise++;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic frame(input logic [7:0] code, input logic [31:0] a, input int n, input int stall);
    logic [31:0] ea;
    int aw, dw, dm, clk, got;
    logic ok, seen_done, act_seen;
    cw = (proto == SFR_PROTO_QUAD) ? 4 : ((proto == SFR_PROTO_DUAL) ? 2 : 1);
    lmask = (cw == 4) ? 4'hF : ((cw == 2) ? 4'h3 : 4'h1);
    case (proto)
      SFR_PROTO_DUAL: ok = code inside {8'h0B, 8'h0D, 8'h3B, 8'h3D, 8'hBB, 8'hBD};
      SFR_PROTO_QUAD: ok = code inside {8'h0B, 8'h0D, 8'h6B, 8'h6D, 8'hEB, 8'hED};
      default: ok = code inside {codes};
    endcase
    aw = cw;
    dw = cw;
    dm = (cw == 2) ? 7 : 9;
    if (cw == 1) begin
      aw = (code[7:4] == 4'hB) ? 2 : ((code[7:4] == 4'hE) ? 4 : 1);
      dw = (code[7:4] == 4'h0) ? 1 : ((code[7:4] inside {4'h3, 4'hB}) ? 2 : 4);
      dm = (code == 8'h03) ? 0 : ((code[7:4] == 4'h0) ? 8 : ((code[7:4] == 4'hE) ? 9 : 7));
    end
    clk = ok ? 8 / cw + ((wide === 1'b1) ? 32 : 24) / aw + dm + 8 * n / dw : 8 / cw;
    ea = (wide === 1'b1) ? a : {8'h00, a[23:0]};
    req_code <= code;
    req_addr <= a;
    req_len <= 16'(n - 1);
    req_valid <= 1'b1;
    rd_ready <= (stall == 0);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    got = 0;
    seen_done = 1'b0;
    act_seen = 1'b0;
    for (int k = 0; k < 20000 && !(seen_done && (got == n || !ok)); k++) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        chk("rd_data", rd_data, mem_byte(ea));
        ea = {ea[31:25], ea[24:0] + 25'h1};
        got++;
      end
      if (done === 1'b1) seen_done = 1'b1;
      if (rd_act === 1'b1) act_seen = 1'b1;
      @(posedge sys_clk);
      // ready only ever rises here, so back-to-back frames never drive it twice in a step
      if (k + 1 == stall) rd_ready <= 1'b1;
    end
    chk("bytes", got, ok ? n : 0);
    chk("data_phase", act_seen, ok);
    chk("req_ready", req_ready, 1'b1);
    chk("sck_rises", n_rise, clk);
    chk("command", cmd_sh, code);
    chk("read_active", rd_act, 1'b0);
    chk("rd_valid", rd_valid, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, nv_wide, wide, req_valid, rd_ready} = '0;
    proto = SFR_PROTO_EXT;
    {req_code, req_addr, req_len} = '0;
    {n_mismatch, tests_run, cyc, n_rise, cw} = '0;
    lmask = 4'h1;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk("wide_mode", wide_act, 1'b0);
    for (int p = 0; p < 3; p++) begin
      proto <= sfr_proto_t'(p);
      @(posedge sys_clk);
      foreach (codes[i]) frame(codes[i], 32'hA5123456 + i, 2, 0);
    end
    proto <= SFR_PROTO_EXT;
    @(posedge sys_clk);
    // host stalls with a full buffer; no byte may go missing
    // ready held off past the second byte, so the buffer really fills
    frame(8'hEB, 32'h00FFFFFE, 6, 300);
    frame(SFR_CMD_WIDE_ENTER, 32'h0, 1, 0);
    chk("wide_mode", wide_act, 1'b1);
    wide <= 1'b1;
    @(posedge sys_clk);
    frame(8'h0B, 32'h03FFFFFE, 4, 0);
    frame(SFR_CMD_WIDE_LEAVE, 32'h0, 1, 0);
    chk("wide_mode", wide_act, 1'b0);
    nv_wide <= 1'b1;
    nrst <= 1'b0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk("wide_mode", wide_act, 1'b1);
    frame(8'h03, 32'h81234567, 1, 0);
    complete_run();
  end
endmodule // serial_flash_read_path_test
